//--- ssq_status_queue.sv
// Purpose: Event latching, enable masking, status byte and output queue.
// Assumes: Commands, events and busy come from logic on core_clk.
// Notes: Status byte lags its sources by one clock.
`timescale 1ns/1ps
`include "ssq_params.svh"

// Contract
// - AND event with enable, OR into summary
// - Summary high sets its status byte bit
// - Standard mask holds 0..255, reads back
// - Wide masks hold 0..32767, read back
// - Reset and preset zero masks; clear keeps
// - Writing zero clears a mask
// - Measurement summary drives status bit B0
// - Reading ready at B5, enabled by 32
// - Buffer half at B8, enabled by 256
// - Writing 512 enables only buffer full
// - Operation complete at B0, enabled by 1
// - Standard summary drives status bit B5
// - Operation complete waits for idle activity
// - Query responses enter first-in first-out queue
// - Queue data sets message waiting bit
// - Host read removes message from queue
// - Empty queue clears message waiting bit
// - Event bits latch until cleared
// - Event read, clear, reset zero events
module ssq_status_queue
  import ssq_pkg::*;
#(
  parameter int QUEUE_DEPTH = 2,
  parameter int DATA_W = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire ssq_cmd_t cmd_code,
  input wire logic [15:0] cmd_data,
  output logic cmd_ready,
  input wire logic [7:0] std_event_set,
  input wire logic [15:0] oper_event_set,
  input wire logic [15:0] meas_event_set,
  input wire logic [15:0] ques_event_set,
  input wire logic reading_ready_flag,
  input wire logic buffer_half_flag,
  input wire logic buffer_full_flag,
  input wire logic activity_busy,
  output logic out_valid,
  output logic [DATA_W-1:0] out_data,
  input wire logic out_ready,
  output logic [7:0] status_byte
);

  // ==========================================================
  // Configuration check
  generate
    if (QUEUE_DEPTH < 2 || DATA_W < 16) begin : g_bad_cfg
      $error("ssq_status_queue: depth below 2 or data narrower than 16");
    end
  endgenerate

  // ==========================================================
  // Helpers
  function automatic logic summary(input logic [15:0] ev, input logic [15:0] en);
    summary = |(ev & en);
  endfunction

  // Set wins over clear so a coincident event is kept
  function automatic logic [15:0] latch(input logic [15:0] ev, input logic [15:0] set,
                                        input logic clr);
    latch = (clr ? `SSQ_EVENT_RESET : ev) | set;
  endfunction

  // ==========================================================
  // State
  logic [7:0] std_event_mask;
  logic [15:0] operation_event_mask;
  logic [15:0] measurement_event_mask;
  logic [15:0] questionable_event_mask;
  logic [7:0] std_event;
  logic [15:0] oper_event;
  logic [15:0] meas_event;
  logic [15:0] ques_event;
  logic opc_armed;
  logic [QUEUE_DEPTH-1:0] q_valid;
  logic [DATA_W-1:0] q_data [QUEUE_DEPTH];

  logic accept;
  logic pop;
  logic push;
  logic [DATA_W-1:0] push_data;
  logic [QUEUE_DEPTH-1:0] keep_valid;
  logic [QUEUE_DEPTH-1:0] next_valid;
  logic [QUEUE_DEPTH-1:0] slot;
  logic [DATA_W-1:0] shifted [QUEUE_DEPTH];
  logic [15:0] next_resp;
  logic is_query;
  logic clr_std;
  logic clr_oper;
  logic clr_meas;
  logic clr_ques;
  logic opc_set;
  logic [15:0] meas_set_all;
  logic [7:0] std_set_all;
  logic [15:0] std_latched;
  logic [7:0] next_stb;

  assign accept = cmd_valid & cmd_ready;
  assign pop = q_valid[0] & out_ready;

  // ==========================================================
  // Command decode and response
  always_comb begin
    next_resp = 16'h0000;
    is_query = 1'b0;
    clr_std = 1'b0;
    clr_oper = 1'b0;
    clr_meas = 1'b0;
    clr_ques = 1'b0;
    unique case (cmd_code)
      SSQ_SET_STD_MASK, SSQ_SET_OPER_MASK, SSQ_SET_MEAS_MASK, SSQ_SET_QUES_MASK,
      SSQ_PRESET, SSQ_OP_COMPLETE: begin
        is_query = 1'b0;
      end
      SSQ_GET_STD_MASK: begin
        is_query = 1'b1;
        next_resp = {8'h00, std_event_mask};
      end
      SSQ_GET_OPER_MASK: begin
        is_query = 1'b1;
        next_resp = operation_event_mask;
      end
      SSQ_GET_MEAS_MASK: begin
        is_query = 1'b1;
        next_resp = measurement_event_mask;
      end
      SSQ_GET_QUES_MASK: begin
        is_query = 1'b1;
        next_resp = questionable_event_mask;
      end
      SSQ_GET_STD_EVENT: begin
        is_query = 1'b1;
        next_resp = {8'h00, std_event};
        clr_std = 1'b1;
      end
      SSQ_GET_OPER_EVENT: begin
        is_query = 1'b1;
        next_resp = oper_event;
        clr_oper = 1'b1;
      end
      SSQ_GET_MEAS_EVENT: begin
        is_query = 1'b1;
        next_resp = meas_event;
        clr_meas = 1'b1;
      end
      SSQ_GET_QUES_EVENT: begin
        is_query = 1'b1;
        next_resp = ques_event;
        clr_ques = 1'b1;
      end
      SSQ_GET_STATUS_BYTE: begin
        is_query = 1'b1;
        next_resp = {8'h00, status_byte};
      end
      SSQ_CLEAR_STATUS: begin
        clr_std = 1'b1;
        clr_oper = 1'b1;
        clr_meas = 1'b1;
        clr_ques = 1'b1;
      end
    endcase
  end

  assign push = accept & is_query;
  assign push_data = DATA_W'(next_resp);

  // ==========================================================
  // Enable masks
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      std_event_mask <= `SSQ_STD_MASK_RESET;
      operation_event_mask <= `SSQ_WIDE_MASK_RESET;
      measurement_event_mask <= `SSQ_WIDE_MASK_RESET;
      questionable_event_mask <= `SSQ_WIDE_MASK_RESET;
    end else if (accept) begin
      // Clear-status leaves masks alone; only preset zeroes them
      unique case (cmd_code)
        SSQ_PRESET: begin
          std_event_mask <= `SSQ_STD_MASK_RESET;
          operation_event_mask <= `SSQ_WIDE_MASK_RESET;
          measurement_event_mask <= `SSQ_WIDE_MASK_RESET;
          questionable_event_mask <= `SSQ_WIDE_MASK_RESET;
        end
        SSQ_SET_STD_MASK: begin
          std_event_mask <= cmd_data[7:0];
        end
        SSQ_SET_OPER_MASK: begin
          operation_event_mask <= cmd_data & `SSQ_WIDE_MASK_LEGAL;
        end
        SSQ_SET_MEAS_MASK: begin
          // Value 32, 256 or 512 opens one named flag
          measurement_event_mask <= cmd_data & `SSQ_WIDE_MASK_LEGAL;
        end
        SSQ_SET_QUES_MASK: begin
          questionable_event_mask <= cmd_data & `SSQ_WIDE_MASK_LEGAL;
        end
        default: begin
          std_event_mask <= std_event_mask;
        end
      endcase
    end
  end

  // ==========================================================
  // Operation complete tracking
  assign opc_set = opc_armed & ~activity_busy;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      opc_armed <= 1'b0;
    end else if (accept && cmd_code == SSQ_OP_COMPLETE) begin
      opc_armed <= 1'b1;
    end else if (opc_set || (accept && cmd_code == SSQ_CLEAR_STATUS)) begin
      opc_armed <= 1'b0;
    end
  end

  // ==========================================================
  // Event registers
  always_comb begin
    std_set_all = std_event_set;
    std_set_all[`SSQ_STD_OPC_BIT] = std_event_set[`SSQ_STD_OPC_BIT] | opc_set;
    meas_set_all = meas_event_set;
    meas_set_all[`SSQ_MEAS_READY_BIT] = meas_event_set[`SSQ_MEAS_READY_BIT] |
                                        reading_ready_flag;
    meas_set_all[`SSQ_MEAS_HALF_BIT] = meas_event_set[`SSQ_MEAS_HALF_BIT] |
                                       buffer_half_flag;
    meas_set_all[`SSQ_MEAS_FULL_BIT] = meas_event_set[`SSQ_MEAS_FULL_BIT] |
                                       buffer_full_flag;
  end

  // Widened for the shared helper, cut back to the standard width below
  assign std_latched = latch({8'h00, std_event}, {8'h00, std_set_all}, accept & clr_std);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      std_event <= `SSQ_STD_MASK_RESET;
      oper_event <= `SSQ_EVENT_RESET;
      meas_event <= `SSQ_EVENT_RESET;
      ques_event <= `SSQ_EVENT_RESET;
    end else begin
      std_event <= std_latched[7:0];
      oper_event <= latch(oper_event, oper_event_set, accept & clr_oper);
      meas_event <= latch(meas_event, meas_set_all, accept & clr_meas);
      ques_event <= latch(ques_event, ques_event_set, accept & clr_ques);
    end
  end

  // ==========================================================
  // Status byte
  always_comb begin
    next_stb = `SSQ_STB_RESET;
    next_stb[`SSQ_STB_MEAS_BIT] = summary(meas_event, measurement_event_mask);
    next_stb[`SSQ_STB_QUES_BIT] = summary(ques_event, questionable_event_mask);
    next_stb[`SSQ_STB_STD_BIT] = summary({8'h00, std_event},
                                         {8'h00, std_event_mask});
    next_stb[`SSQ_STB_OPER_BIT] = summary(oper_event, operation_event_mask);
    next_stb[`SSQ_STB_MSG_BIT] = q_valid[0];
  end

  // Levels only, so a cleared event or mask drops its bit next clock
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_byte <= `SSQ_STB_RESET;
    end else begin
      status_byte <= next_stb;
    end
  end

  // ==========================================================
  // Output queue, head always in entry zero
  assign keep_valid = pop ? (q_valid >> 1) : q_valid;

  genvar gi;
  generate
    for (gi = 0; gi < QUEUE_DEPTH; gi++) begin : g_entry
      if (gi == QUEUE_DEPTH - 1) begin : g_last
        assign shifted[gi] = pop ? '0 : q_data[gi];
      end else begin : g_mid
        assign shifted[gi] = pop ? q_data[gi+1] : q_data[gi];
      end
      if (gi == 0) begin : g_first
        assign slot[gi] = ~keep_valid[gi];
      end else begin : g_rest
        assign slot[gi] = ~keep_valid[gi] & keep_valid[gi-1];
      end
      assign next_valid[gi] = keep_valid[gi] | (push & slot[gi]);

      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          q_data[gi] <= '0;
        end else if (push && slot[gi]) begin
          q_data[gi] <= push_data;
        end else begin
          q_data[gi] <= shifted[gi];
        end
      end
    end
  endgenerate

  // A full queue stalls every command, which keeps a query from being lost
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_valid <= '0;
      cmd_ready <= 1'b1;
    end else begin
      q_valid <= next_valid;
      cmd_ready <= ~&next_valid;
    end
  end

  assign out_valid = q_valid[0];
  assign out_data = q_data[0];

endmodule // ssq_status_queue

//--- ssq_params.svh
// Purpose: Constants of the status summary and output queue block.
// Assumes: Included by its bare name wherever the numbers are needed.
// Notes: Bit positions count from zero; wide masks keep only bits 0..14 (16'h7FFF).
`ifndef SSQ_PARAMS_SVH
`define SSQ_PARAMS_SVH

// ==========================================================
// Register widths and reset values
`define SSQ_STD_W 8
`define SSQ_WIDE_W 16
`define SSQ_STD_MASK_RESET 8'h00
`define SSQ_WIDE_MASK_RESET 16'h0000
`define SSQ_WIDE_MASK_LEGAL 16'h7FFF
`define SSQ_EVENT_RESET 16'h0000
`define SSQ_STB_RESET 8'h00

// ==========================================================
// Status byte summary positions
`define SSQ_STB_MEAS_BIT 0
`define SSQ_STB_QUES_BIT 3
`define SSQ_STB_MSG_BIT 4
`define SSQ_STB_STD_BIT 5
`define SSQ_STB_OPER_BIT 7

// ==========================================================
// Named event positions
`define SSQ_STD_OPC_BIT 0
`define SSQ_MEAS_READY_BIT 5
`define SSQ_MEAS_HALF_BIT 8
`define SSQ_MEAS_FULL_BIT 9

`endif

//--- ssq_pkg.sv
// Purpose: Types shared by the status summary block and its users.
// Assumes: Commands arrive already parsed, one per accepted cycle.
// Notes: The command set fills the 4-bit code space exactly.
package ssq_pkg;

  // ==========================================================
  // Parsed host commands
  typedef enum logic [3:0] {
    SSQ_SET_STD_MASK,
    SSQ_SET_OPER_MASK,
    SSQ_SET_MEAS_MASK,
    SSQ_SET_QUES_MASK,
    SSQ_GET_STD_MASK,
    SSQ_GET_OPER_MASK,
    SSQ_GET_MEAS_MASK,
    SSQ_GET_QUES_MASK,
    SSQ_GET_STD_EVENT,
    SSQ_GET_OPER_EVENT,
    SSQ_GET_MEAS_EVENT,
    SSQ_GET_QUES_EVENT,
    SSQ_GET_STATUS_BYTE,
    SSQ_CLEAR_STATUS,
    SSQ_PRESET,
    SSQ_OP_COMPLETE
  } ssq_cmd_t;

endpackage

//--- ssq_host_model.sv
// Purpose: Host reading the output queue as talker.
// Assumes: stall holds the reader off, like a slow controller.
// Notes: Each word taken is echoed for one cycle on rx_stb.
`timescale 1ns/1ps
module ssq_host_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic stall,
  input wire logic out_valid,
  input wire logic [15:0] out_data,
  output logic out_ready,
  output logic rx_stb,
  output logic [15:0] rx_word
);
  // ==========================================================
  // Talker read, only once a query has queued a word
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_ready <= 1'b0;
      rx_stb <= 1'b0;
      rx_word <= 16'h0000;
    end else begin
      out_ready <= !stall;
      rx_stb <= out_valid && out_ready;
      rx_word <= out_data;
    end
  end
endmodule // ssq_host_model

//--- ssq_status_queue_props.sv
// Purpose: Port-level checks of summaries, masks and queue.
// Assumes: Mask copies track only commands taken at the port.
// Notes: The summary-set check skips cycles where a command may move a mask.
`timescale 1ns/1ps
`include "ssq_params.svh"
module ssq_status_queue_props
  import ssq_pkg::*;
#(
  parameter int QUEUE_DEPTH = 2,
  parameter int DATA_W = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire ssq_cmd_t cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic cmd_ready,
  input wire logic [7:0] std_event_set,
  input wire logic [15:0] oper_event_set,
  input wire logic [15:0] meas_event_set,
  input wire logic [15:0] ques_event_set,
  input wire logic reading_ready_flag,
  input wire logic buffer_half_flag,
  input wire logic buffer_full_flag,
  input wire logic out_valid,
  input wire logic [DATA_W-1:0] out_data,
  input wire logic out_ready,
  input wire logic [7:0] status_byte
);
  logic take, q;
  logic [7:0] ms, hit;
  logic [15:0] mo, mm, mq, meas_in, rb;
  int occ;
  assign take = cmd_valid && cmd_ready;
  assign q = cmd_code inside {[SSQ_GET_STD_MASK:SSQ_GET_STATUS_BYTE]};
  assign meas_in = meas_event_set
    | {6'h00, buffer_full_flag, buffer_half_flag, 2'h0, reading_ready_flag, 5'h00};
  assign hit = {|(oper_event_set & mo), 1'b0, |(std_event_set & ms), 1'b0,
    |(ques_event_set & mq), 2'h0, |(meas_in & mm)};
  always_comb begin
    case (cmd_code)
      SSQ_GET_STD_MASK: rb = {8'h00, ms};
      SSQ_GET_OPER_MASK: rb = mo;
      SSQ_GET_MEAS_MASK: rb = mm;
      default: rb = mq;
    endcase
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {ms, mo, mm, mq} <= 56'h0;
    end else if (take) begin
      case (cmd_code)
        SSQ_SET_STD_MASK: ms <= cmd_data[7:0];
        SSQ_SET_OPER_MASK: mo <= cmd_data & 16'h7FFF;
        SSQ_SET_MEAS_MASK: mm <= cmd_data & 16'h7FFF;
        SSQ_SET_QUES_MASK: mq <= cmd_data & 16'h7FFF;
        SSQ_PRESET: {ms, mo, mm, mq} <= 56'h0;
        default: ;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      occ <= 0;
    end else begin
      occ <= occ + int'(take && q) - int'(out_valid && out_ready);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // Assertions
  chk_summary_set:
    assert property (!take && |hit |=> ##1 (status_byte & $past(hit, 2)) == $past(hit, 2))
    else $error("summary bit not set");
  chk_preset_zero:
    assert property (take && cmd_code == SSQ_PRESET |=> ##1 (status_byte & 8'hA9) == 8'h00)
    else $error("summary left after preset");
  chk_clear_drop:
    assert property (take && cmd_code == SSQ_CLEAR_STATUS && hit == 8'h00
      |=> ##1 (status_byte & 8'h89) == 8'h00) else $error("summary left after clear");
  chk_answer_next:
    assert property (take && q && !out_valid |=> out_valid) else $error("no answer");
  chk_mask_back:
    assert property (take && cmd_code inside {[SSQ_GET_STD_MASK:SSQ_GET_QUES_MASK]}
      && !out_valid |=> out_data == DATA_W'($past(rb))) else $error("bad mask readback");
  chk_head_hold:
    assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("head lost unread");
  chk_msg_set:
    assert property ($rose(out_valid) |=> status_byte[`SSQ_STB_MSG_BIT])
    else $error("message bit not set");
  chk_msg_clear:
    assert property ($fell(out_valid) |=> !status_byte[`SSQ_STB_MSG_BIT])
    else $error("message bit not cleared");
  chk_full_stall:
    assert property (cmd_ready == (occ < QUEUE_DEPTH)) else $error("ready vs fill wrong");
  cover property (!cmd_ready);
  cover property (out_valid && out_ready);
  cover property (status_byte[`SSQ_STB_STD_BIT]);
endmodule // ssq_status_queue_props
bind ssq_status_queue ssq_status_queue_props #(.QUEUE_DEPTH(QUEUE_DEPTH),
  .DATA_W(DATA_W)) i_props (.*);

//--- status_summary_and_output_queue_bench.sv
// Purpose: Self-checking bench of the status summary block.
// Assumes: Host model pops the queue unless stalled.
// Notes: Status bits are read two or more edges after their cause.
`timescale 1ns/1ps
`include "ssq_params.svh"
module status_summary_and_output_queue_bench
  import ssq_pkg::*;
;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  ssq_cmd_t cmd_code = SSQ_PRESET;
  logic [15:0] cmd_data = 16'h0000;
  logic [7:0] std_event_set = 8'h00;
  logic [15:0] oper_event_set = 16'h0000, meas_event_set = 16'h0000, ques_event_set = 16'h0000;
  logic reading_ready_flag = 1'b0, buffer_half_flag = 1'b0, buffer_full_flag = 1'b0;
  logic activity_busy = 1'b0, stall = 1'b0;
  logic cmd_ready, out_valid, out_ready, rx_stb;
  logic [15:0] out_data, rx_word;
  logic [7:0] status_byte;
  logic [15:0] got[$];
  int err_count = 0;
  int n_checks = 0;
  int pos[4] = '{`SSQ_STB_STD_BIT, `SSQ_STB_OPER_BIT, `SSQ_STB_MEAS_BIT, `SSQ_STB_QUES_BIT};
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (rx_stb) got.push_back(rx_word);
  ssq_status_queue #(.QUEUE_DEPTH(2), .DATA_W(16)) i_dut (.*);
  ssq_host_model i_host (.*);
  // ==========================================================
  // Shared tasks
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_word(input string w, input logic [15:0] e, input logic [15:0] a);
    n_checks++;
    if (a !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, a);
    end
  endtask
  task automatic chk_bit(input string w, input logic e, input logic a);
    chk_word(w, {15'h0, e}, {15'h0, a});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic cmd(input ssq_cmd_t c, input logic [15:0] d = 16'h0000);
    int n = 0;
    cmd_code <= c;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    @(posedge core_clk);
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    cmd_valid <= 1'b0;
    if (cmd_ready !== 1'b1) begin
      err_count++;
      $display("[FAIL] cmd_ready expected 1 seen %b", cmd_ready);
    end
    // One idle edge so a following command never re-drives valid in this step
    @(posedge core_clk);
  endtask
  task automatic rsp(input string w, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
    int n = 0;
    while (got.size() == 0 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    chk_word(w, e, (got.size() > 0) ? (got.pop_front() & m) : 16'hXXXX);
  endtask
  task automatic pulse(input int i, input logic [15:0] v);
    case (i)
      0: std_event_set <= v[7:0];
      1: oper_event_set <= v;
      2: meas_event_set <= v;
      default: ques_event_set <= v;
    endcase
    tick(1);
    {std_event_set, oper_event_set, meas_event_set, ques_event_set} <= 56'h0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_masks();
    for (int i = 0; i < 4; i++) begin
      cmd(ssq_cmd_t'(4 + i));
      rsp("mask at reset", 16'h0000);
      cmd(ssq_cmd_t'(i), (i == 0) ? 16'h00FF : 16'h7FFF);
      cmd(ssq_cmd_t'(4 + i));
      rsp("mask max", (i == 0) ? 16'h00FF : 16'h7FFF);
      cmd(ssq_cmd_t'(i), 16'h0000);
      cmd(ssq_cmd_t'(4 + i));
      rsp("mask zeroed", 16'h0000);
    end
  endtask
  task automatic t_summary();
    for (int i = 0; i < 4; i++) begin
      cmd(ssq_cmd_t'(i), 16'h0004);
      pulse(i, 16'h0002);
      tick(3);
      chk_bit("summary masked", 1'b0, status_byte[pos[i]]);
      pulse(i, 16'h0004);
      tick(6);
      chk_bit("summary held", 1'b1, status_byte[pos[i]]);
      cmd(ssq_cmd_t'(8 + i));
      rsp("event read", 16'h0006);
      tick(2);
      chk_bit("summary dropped", 1'b0, status_byte[pos[i]]);
      cmd(ssq_cmd_t'(i), 16'h0000);
    end
  endtask
  task automatic t_flags();
    logic [15:0] m[3] = '{16'h0020, 16'h0100, 16'h0200};
    cmd(SSQ_PRESET);
    for (int k = 0; k < 3; k++) begin
      cmd(SSQ_SET_MEAS_MASK, m[k]);
      {buffer_full_flag, buffer_half_flag, reading_ready_flag} <= 3'h7 ^ (3'h1 << k);
      tick(1);
      {buffer_full_flag, buffer_half_flag, reading_ready_flag} <= 3'h0;
      tick(3);
      chk_bit("other flags", 1'b0, status_byte[`SSQ_STB_MEAS_BIT]);
      {buffer_full_flag, buffer_half_flag, reading_ready_flag} <= 3'h1 << k;
      tick(1);
      {buffer_full_flag, buffer_half_flag, reading_ready_flag} <= 3'h0;
      tick(3);
      cmd(SSQ_GET_STATUS_BYTE);
      rsp("status b0", 16'h0001, 16'h0001);
      cmd(SSQ_GET_MEAS_EVENT);
      rsp("flag events", 16'h0320);
    end
  endtask
  task automatic t_opc();
    cmd(SSQ_SET_STD_MASK, 16'h0001);
    activity_busy <= 1'b1;
    cmd(SSQ_OP_COMPLETE);
    tick(8);
    chk_bit("done while busy", 1'b0, status_byte[`SSQ_STB_STD_BIT]);
    activity_busy <= 1'b0;
    tick(4);
    chk_bit("done when idle", 1'b1, status_byte[`SSQ_STB_STD_BIT]);
    cmd(SSQ_CLEAR_STATUS);
    tick(3);
    chk_bit("done cleared", 1'b0, status_byte[`SSQ_STB_STD_BIT]);
  endtask
  task automatic t_queue();
    cmd(SSQ_SET_OPER_MASK, 16'h1234);
    stall <= 1'b1;
    cmd(SSQ_GET_OPER_MASK);
    cmd(SSQ_GET_STD_MASK);
    tick(2);
    chk_bit("full stalls", 1'b0, cmd_ready);
    chk_bit("message set", 1'b1, status_byte[`SSQ_STB_MSG_BIT]);
    stall <= 1'b0;
    rsp("queue head", 16'h1234);
    rsp("mask kept by clear", 16'h0001);
    tick(3);
    chk_bit("message gone", 1'b0, status_byte[`SSQ_STB_MSG_BIT]);
  endtask
  initial begin
    tick(5);
    arst_n <= 1'b1;
    tick(1);
    t_masks();
    t_summary();
    t_flags();
    t_opc();
    t_queue();
    test_done();
  end
  initial begin
    tick(20000);
    err_count++;
    test_done();
  end
endmodule // status_summary_and_output_queue_bench
